/* File: pkg/cond_coll_consts.svh */
// Register offsets, field positions, reset values and timing limits of the condition unit.
// Included by the package and the design; definitions only.
`ifndef COND_COLL_CONSTS_SVH
`define COND_COLL_CONSTS_SVH

`define OFS_RELOAD 8'h00
`define OFS_CONTROL_TWO 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_CLEAR 8'h10
`define OFS_IRQ_ENABLE 8'h14

`define BIT_START 0
`define BIT_RESTART 1
`define BIT_STOP 2

`define EV_COLLISION 0
`define EV_DONE 1

`define RELOAD_RESET 8'h09
`define RELOAD_MIN 8'h03

`endif

/* File: pkg/cond_coll_pkg.sv */
// Types shared by the condition unit: state codes, line levels and bus request fields.
// Assumes cond_coll_consts.svh in the include path.
`include "cond_coll_consts.svh"
package cond_coll_pkg;

typedef enum logic [3:0] {
	ST_IDLE = 4'b0000,
	ST_S_CHECK = 4'b0001,
	ST_S_COUNT1 = 4'b0010,
	ST_S_COUNT2 = 4'b0011,
	ST_R_COUNT1 = 4'b0100,
	ST_R_SCLWAIT = 4'b0101,
	ST_R_COUNT2 = 4'b0110,
	ST_R_COUNT3 = 4'b0111,
	ST_P_SDAWAIT = 4'b1000,
	ST_P_SCLWAIT = 4'b1001,
	ST_P_COUNT1 = 4'b1010,
	ST_P_COUNT2 = 4'b1011
} cond_state_e;

typedef struct packed {
	logic data;
	logic clock;
} line_level_s;

typedef struct packed {
	logic [7:0] addr;
	logic write;
} bus_req_s;

endpackage

/* File: hdl/cond_collision.sv */
// Start, repeated start and stop generation with bus collision detection, AHB-Lite slave.
// Assumes the line inputs are asynchronous, open-drain pads resolved outside.
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
`include "cond_coll_consts.svh"

module cond_collision #(
	parameter int RELOAD_WIDTH = 8
)(
	// System
	input wire logic CLK,
	input wire logic SRST,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Bus lines, open drain
	input wire logic BUS_DATA_PIN_IN,
	output logic BUS_DATA_PIN_OUT,
	output logic BUS_DATA_PIN_OE,
	input wire logic BUS_CLOCK_PIN_IN,
	output logic BUS_CLOCK_PIN_OUT,
	output logic BUS_CLOCK_PIN_OE,
	// Interrupt
	output logic IRQ
);
	import cond_coll_pkg::*;

	// Narrower than 4 bits would truncate the reset reload value
	if (RELOAD_WIDTH < 4 || RELOAD_WIDTH > 8)
	begin : gen_width_check
		$error("RELOAD_WIDTH must lie in 4..8");
	end

	// Synchroniser and line view
	line_level_s sync1;
	line_level_s sync2;
	line_level_s line;

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			sync1 <= '{data: 1'b1, clock: 1'b1};
			sync2 <= '{data: 1'b1, clock: 1'b1};
		end
		else
		begin
			sync1 <= '{data: BUS_DATA_PIN_IN, clock: BUS_CLOCK_PIN_IN};
			sync2 <= sync1;
		end
	end
	assign line = sync2;

	// Registers
	logic [RELOAD_WIDTH-1:0] reload;
	logic [2:0] request;
	logic [1:0] irq_status;
	logic [1:0] irq_enable;
	bus_req_s dphase;
	logic dphase_valid;
	logic take;

	cond_state_e state;
	logic [RELOAD_WIDTH-1:0] baud_down_counter;
	logic drive_data_low;
	logic drive_clock_low;
	logic collision;
	logic done;

	assign take = HSEL && HREADY && HTRANS[1];

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			dphase_valid <= 1'b0;
			dphase <= '0;
		end
		else
		begin
			dphase_valid <= take;
			if (take)
				dphase <= '{addr: HADDR[7:0], write: HWRITE};
		end
	end

	function automatic logic is_write(input bus_req_s r, input logic v, input logic [7:0] ofs);
		is_write = v && r.write && (r.addr[7:2] == ofs[7:2]);
	endfunction

	always_ff @(posedge CLK)
	begin
		if (SRST)
			reload <= RELOAD_WIDTH'(`RELOAD_RESET);
		else if (is_write(dphase, dphase_valid, `OFS_RELOAD))
			reload <= HWDATA[RELOAD_WIDTH-1:0];
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			irq_enable <= 2'h0;
		else if (is_write(dphase, dphase_valid, `OFS_IRQ_ENABLE))
			irq_enable <= HWDATA[1:0];
	end

	// Set wins over a simultaneous clear
	always_ff @(posedge CLK)
	begin
		if (SRST)
			irq_status <= 2'h0;
		else
		begin
			if (is_write(dphase, dphase_valid, `OFS_IRQ_CLEAR))
				irq_status <= (irq_status & ~HWDATA[1:0]) | {done, collision};
			else
				irq_status <= irq_status | {done, collision};
		end
	end

	assign IRQ = |(irq_status & irq_enable);

	// Requests: one at a time; priority start, restart, stop; self-clearing
	always_ff @(posedge CLK)
	begin
		if (SRST)
			request <= 3'h0;
		else if (collision || done)
			request <= 3'h0;
		else if (is_write(dphase, dphase_valid, `OFS_CONTROL_TWO) && request == 3'h0)
		begin
			if (HWDATA[`BIT_START])
				request <= 3'b001;
			else if (HWDATA[`BIT_RESTART])
				request <= 3'b010;
			else if (HWDATA[`BIT_STOP])
				request <= 3'b100;
		end
	end

	always_comb
	begin
		HRDATA = 32'h0;
		if (dphase_valid && !dphase.write)
		begin
			unique case (dphase.addr[7:2])
				6'(`OFS_RELOAD >> 2): HRDATA = 32'(reload);
				6'(`OFS_CONTROL_TWO >> 2): HRDATA = {29'h0, request};
				6'(`OFS_STATUS >> 2): HRDATA = {24'h0, state, 2'h0, line.clock, line.data};
				6'(`OFS_IRQ_STATUS >> 2): HRDATA = {30'h0, irq_status};
				6'(`OFS_IRQ_ENABLE >> 2): HRDATA = {30'h0, irq_enable};
				default: HRDATA = 32'h0;
			endcase
		end
	end
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	// Condition sequencer
	logic expired;
	assign expired = (baud_down_counter == '0);

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			state <= ST_IDLE;
			baud_down_counter <= '0;
			drive_data_low <= 1'b0;
			drive_clock_low <= 1'b0;
			collision <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			collision <= 1'b0;
			done <= 1'b0;
			if (!expired)
				baud_down_counter <= baud_down_counter - 1'b1;
			unique case (state)
				ST_IDLE:
				begin
					if (request[`BIT_START] && !done && !collision)
					begin
						drive_data_low <= 1'b0;
						drive_clock_low <= 1'b0;
						state <= ST_S_CHECK;
					end
					else if (request[`BIT_RESTART] && !done && !collision)
					begin
						drive_data_low <= 1'b0;
						baud_down_counter <= reload;
						state <= ST_R_COUNT1;
					end
					else if (request[`BIT_STOP] && !done && !collision)
					begin
						drive_data_low <= 1'b1;
						state <= ST_P_SDAWAIT;
					end
				end
				ST_S_CHECK:
				begin
					if (!line.data || !line.clock)
					begin
						collision <= 1'b1;
						state <= ST_IDLE;
					end
					else
					begin
						baud_down_counter <= reload;
						state <= ST_S_COUNT1;
					end
				end
				ST_S_COUNT1:
				begin
					if (!line.data)
					begin
						// Another master started first; follow it, no flag
						baud_down_counter <= reload;
						drive_data_low <= 1'b1;
						state <= ST_S_COUNT2;
					end
					else if (!line.clock)
					begin
						collision <= 1'b1;
						state <= ST_IDLE;
					end
					else if (expired)
					begin
						drive_data_low <= 1'b1;
						baud_down_counter <= reload;
						state <= ST_S_COUNT2;
					end
				end
				ST_S_COUNT2:
				begin
					if (expired)
					begin
						drive_clock_low <= 1'b1;
						done <= 1'b1;
						state <= ST_IDLE;
					end
				end
				ST_R_COUNT1:
				begin
					if (expired)
					begin
						drive_clock_low <= 1'b0;
						state <= ST_R_SCLWAIT;
					end
				end
				ST_R_SCLWAIT:
				begin
					if (line.clock)
					begin
						if (!line.data)
						begin
							collision <= 1'b1;
							state <= ST_IDLE;
						end
						else
						begin
							baud_down_counter <= reload;
							state <= ST_R_COUNT2;
						end
					end
				end
				ST_R_COUNT2:
				begin
					if (!line.clock && line.data)
					begin
						collision <= 1'b1;
						state <= ST_IDLE;
					end
					else if (!line.data)
					begin
						// Falling data from another master is arbitration, not collision
						drive_data_low <= 1'b1;
						baud_down_counter <= reload;
						state <= ST_R_COUNT3;
					end
					else if (expired)
					begin
						drive_data_low <= 1'b1;
						baud_down_counter <= reload;
						state <= ST_R_COUNT3;
					end
				end
				ST_R_COUNT3:
				begin
					if (expired)
					begin
						drive_clock_low <= 1'b1;
						done <= 1'b1;
						state <= ST_IDLE;
					end
				end
				ST_P_SDAWAIT:
				begin
					if (!line.data)
					begin
						drive_clock_low <= 1'b0;
						state <= ST_P_SCLWAIT;
					end
				end
				ST_P_SCLWAIT:
				begin
					if (line.clock)
					begin
						baud_down_counter <= reload;
						state <= ST_P_COUNT1;
					end
				end
				ST_P_COUNT1:
				begin
					if (!line.clock)
					begin
						collision <= 1'b1;
						state <= ST_IDLE;
					end
					else if (expired)
					begin
						drive_data_low <= 1'b0;
						baud_down_counter <= reload;
						state <= ST_P_COUNT2;
					end
				end
				ST_P_COUNT2:
				begin
					if (!line.clock && !line.data)
					begin
						collision <= 1'b1;
						state <= ST_IDLE;
					end
					else if (expired)
					begin
						if (!line.data)
							collision <= 1'b1;
						else
							done <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
			if (state != ST_IDLE && state != ST_S_COUNT2 && state != ST_R_COUNT3
				&& state != ST_S_CHECK && next_abort(state, line))
			begin
				drive_data_low <= 1'b0;
				drive_clock_low <= 1'b0;
			end
			else if (state == ST_S_CHECK && (!line.data || !line.clock))
			begin
				drive_data_low <= 1'b0;
				drive_clock_low <= 1'b0;
			end
		end
	end

	// Collision term per state, shared by the release logic
	function automatic logic next_abort(input cond_state_e s, input line_level_s l);
		next_abort = 1'b0;
		unique case (s)
			ST_S_COUNT1: next_abort = l.data && !l.clock;
			ST_R_SCLWAIT: next_abort = l.clock && !l.data;
			ST_R_COUNT2: next_abort = !l.clock && l.data;
			ST_P_COUNT1: next_abort = !l.clock;
			ST_P_COUNT2: next_abort = !l.data && (!l.clock || expired);
			default: next_abort = 1'b0;
		endcase
	endfunction

	// Open-drain drivers: only ever pull low
	assign BUS_DATA_PIN_OUT = 1'b0;
	assign BUS_DATA_PIN_OE = drive_data_low;
	assign BUS_CLOCK_PIN_OUT = 1'b0;
	assign BUS_CLOCK_PIN_OE = drive_clock_low;
endmodule

/* File: testbench/cond_coll_peer.sv */
// Far side of the two-wire bus: pull-ups and a second master.
// Lines are the wired-AND of every pull; released lines float high.
`timescale 1ns/1ns
module cond_coll_peer(
	// Design pulls
	input wire logic data_oe,
	input wire logic clock_oe,
	// Second master pulls
	input wire logic hold_data,
	input wire logic hold_clock,
	input wire logic run_clock,
	// Resolved lines
	output logic data_line,
	output logic clock_line
);
	logic pclk;
	// Own clock, unrelated in phase to the system clock
	initial
	begin
		pclk = 1'b1;
		#7;
		forever #160 pclk = ~pclk;
	end
	// Second master may start first or send a 0
	assign data_line = !(data_oe || hold_data);
	// Clock runs only while its frame is on
	assign clock_line = !(clock_oe || hold_clock || (run_clock && !pclk));
endmodule

/* File: testbench/cond_coll_assertions.sv */
// Port checker for the condition unit, bound after the module.
// Sees the top module's pins only.
`timescale 1ns/1ns
module cond_coll_chk(
	// Clock, reset
	input wire logic CLK,
	input wire logic SRST,
	// Bus
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	// Lines
	input wire logic BUS_DATA_PIN_IN,
	input wire logic BUS_DATA_PIN_OUT,
	input wire logic BUS_DATA_PIN_OE,
	input wire logic BUS_CLOCK_PIN_OUT,
	input wire logic BUS_CLOCK_PIN_OE,
	input wire logic IRQ
);
	logic dph;
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	always_ff @(posedge CLK)
	begin
		dph <= !SRST && HSEL && HREADY && HTRANS[1];
	end
	chk_reset_lines: assert property ($past(SRST) |-> !BUS_DATA_PIN_OE && !BUS_CLOCK_PIN_OE && !IRQ)
		else $error("lines driven after reset");
	chk_open_drain: assert property (!BUS_DATA_PIN_OUT && !BUS_CLOCK_PIN_OUT)
		else $error("line driven high");
	chk_bus_okay: assert property (HREADYOUT && !HRESP)
		else $error("bus wait or error");
	chk_rdata_idle: assert property (!dph |-> HRDATA == 32'h0)
		else $error("read data outside data phase");
	chk_clock_after_data: assert property ($rose(BUS_CLOCK_PIN_OE) |-> BUS_DATA_PIN_OE && $past(BUS_DATA_PIN_OE, 3))
		else $error("clock pulled without a data count");
	// Clock released in a stop only once data is seen low
	chk_stop_clock_release: assert property ($fell(BUS_CLOCK_PIN_OE) && BUS_DATA_PIN_OE |-> !$past(BUS_DATA_PIN_IN, 2))
		else $error("clock released before data low");
	chk_clock_hold_count: assert property ($rose(BUS_DATA_PIN_OE) && !BUS_CLOCK_PIN_OE |=> !BUS_CLOCK_PIN_OE [*2])
		else $error("clock pulled before count end");
	chk_clock_pull_hold: assert property ($rose(BUS_CLOCK_PIN_OE) |=> BUS_CLOCK_PIN_OE [*2])
		else $error("clock pull dropped");
endmodule

bind cond_collision cond_coll_chk u_chk(.CLK, .SRST, .HSEL, .HTRANS, .HREADY, .HRDATA, .HREADYOUT,
	.HRESP, .BUS_DATA_PIN_IN, .BUS_DATA_PIN_OUT, .BUS_DATA_PIN_OE, .BUS_CLOCK_PIN_OUT,
	.BUS_CLOCK_PIN_OE, .IRQ);

/* File: testbench/cond_collision_tb.sv */
// Register-driven bench of the condition unit against a second master.
// Assumes cond_coll_consts.svh in the include path.
`timescale 1ns/1ns
`include "cond_coll_consts.svh"
module cond_collision_tb;
	logic CLK, SRST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, IRQ;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	logic [31:0] HADDR, HWDATA, HRDATA, r;
	logic doe, coe, din, cin, hd, hc, rc;
	int num_errors, checks, n;
	// Each: request, delay, second-master action, expected status
	logic [15:0] tab [15];
	cond_collision uut(.CLK, .SRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY,
		.HRDATA, .HREADYOUT, .HRESP, .BUS_DATA_PIN_IN(din), .BUS_DATA_PIN_OUT(),
		.BUS_DATA_PIN_OE(doe), .BUS_CLOCK_PIN_IN(cin), .BUS_CLOCK_PIN_OUT(),
		.BUS_CLOCK_PIN_OE(coe), .IRQ);
	cond_coll_peer peer(.data_oe(doe), .clock_oe(coe), .hold_data(hd), .hold_clock(hc),
		.run_clock(rc), .data_line(din), .clock_line(cin));
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h0, a};
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		r = HRDATA;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		cmp(r, e);
	endtask
	task drive(input logic [1:0] a);
		hd <= (a == 2'h1);
		hc <= (a == 2'h2);
		rc <= (a == 2'h3);
	endtask
	task run(input logic [15:0] t);
		if (t[11:4] == 8'h0)
			drive(t[3:2]);
		xfer(1'b1, `OFS_CONTROL_TWO, {28'h0, t[15:12]});
		repeat (t[11:4]) @(posedge CLK);
		drive(t[3:2]);
		n = 0;
		do
		begin
			xfer(1'b0, `OFS_IRQ_STATUS, 32'h0);
			n++;
		end
		while (r[1:0] == 2'h0 && n < 200);
		cmp(r, {30'h0, t[1:0]});
		cmp({31'h0, IRQ}, {31'h0, t[1]});
		cmp({30'h0, doe, coe}, (t[0] || t[14]) ? 32'h0 : 32'h3);
		rd(`OFS_CONTROL_TWO, 32'h0);
		xfer(1'b1, `OFS_IRQ_CLEAR, 32'h3);
		drive(2'h0);
		rd(`OFS_IRQ_STATUS, 32'h0);
	endtask
	task finish_test;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	initial
	begin
		#800000;
		num_errors++;
		finish_test;
	end
	initial
	begin
		SRST = 1'b1;
		HSEL = 1'b1;
		HREADY = 1'b1;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HADDR = 32'h0;
		HWDATA = 32'h0;
		hd = 1'b0;
		hc = 1'b0;
		rc = 1'b0;
		num_errors = 0;
		checks = 0;
		tab = '{16'h1002, 16'h2002, 16'h4002, 16'h1009, 16'h104D, 16'h1046, 16'h2005,
			16'h1002, 16'h4005, 16'h1002, 16'h4089, 16'h1002, 16'h2329, 16'h132A,
			16'h2326};
		repeat (2) @(posedge CLK);
		SRST <= 1'b0;
		@(posedge CLK);
		rd(`OFS_RELOAD, 32'h9);
		rd(`OFS_IRQ_STATUS, 32'h0);
		rd(`OFS_STATUS, 32'h3);
		xfer(1'b1, 8'h18, 32'hFF);
		rd(8'h18, 32'h0);
		xfer(1'b1, `OFS_RELOAD, 32'h20);
		rd(`OFS_RELOAD, 32'h20);
		// Done unmasked, collision masked
		xfer(1'b1, `OFS_IRQ_ENABLE, 32'h2);
		rd(`OFS_IRQ_ENABLE, 32'h2);
		foreach (tab[i])
			run(tab[i]);
		finish_test;
	end
endmodule
